// [include/sst_exec_cfg.svh]
// constants for the skip, subtract, swap and table-read execution block
`ifndef SST_EXEC_CFG_SVH
`define SST_EXEC_CFG_SVH

// ==========================================================
// register byte offsets
`define SST_REG_CMD 8'h00
`define SST_REG_STATUS 8'h04
`define SST_REG_ACC 8'h08
`define SST_REG_FLAGS 8'h0C
`define SST_REG_TABLE_PTR 8'h10
`define SST_REG_TABLE_HIGH 8'h14
`define SST_REG_PC 8'h18
`define SST_REG_DM_ADDR 8'h1C
`define SST_REG_DM_DATA 8'h20

// ==========================================================
// command word fields
`define SST_CMD_OP_MSB 3
`define SST_CMD_OP_LSB 0
`define SST_CMD_ADDR_MSB 11
`define SST_CMD_ADDR_LSB 4
`define SST_CMD_BIT_MSB 14
`define SST_CMD_BIT_LSB 12
`define SST_CMD_IMM_MSB 23
`define SST_CMD_IMM_LSB 16

// ==========================================================
// status and flag bit positions
`define SST_STAT_BUSY 0
`define SST_STAT_SKIP 1
`define SST_FLAG_C 0
`define SST_FLAG_AUX 1
`define SST_FLAG_Z 2
`define SST_FLAG_OVF 3

// ==========================================================
// sizes, values and reset values
`define SST_DM_DEPTH 192
`define SST_PAGE_MSB 11
`define SST_PAGE_LSB 8
`define SST_SET_BYTE_VAL 8'hFF
`define SST_ACC_RST 8'h00
`define SST_PC_RST 12'h000
`define SST_TABLE_PTR_RST 8'h00
`define SST_TABLE_HIGH_RST 7'h00
`define SST_FLAGS_RST 4'h0

`endif

// [include/sst_pkg.sv]
// types shared by the execution block and its helpers
`default_nettype none

package sst_pkg;

	typedef enum logic [3:0] {
		op_set_byte,
		op_set_bit,
		op_incr_skip_zero,
		op_incr_to_acc_skip_zero,
		op_decr_to_acc_skip_zero,
		op_skip_bit_set,
		op_sub_mem,
		op_sub_imm,
		op_subtract_to_memory,
		op_swap,
		op_nibble_swap_to_acc,
		op_skip_if_zero,
		op_move_skip_if_zero,
		op_skip_bit_clear,
		op_table_read_current_page
	} sst_op_t;

	typedef enum logic [1:0] {
		st_idle,
		st_exec,
		st_dummy,
		st_tbl_wait
	} sst_state_t;

	typedef struct packed {
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [7:0] addr;
		sst_op_t op;
	} sst_cmd_t;

	typedef struct packed {
		logic overflow_flag;
		logic zero_flag;
		logic aux_carry_flag;
		logic carry_flag;
	} sst_flags_t;

	typedef struct packed {
		logic [7:0] result;
		sst_flags_t flags;
	} sst_sub_res_t;

endpackage : sst_pkg

`default_nettype wire

// [rtl/sst_sub_alu.sv]
// two's-complement subtractor with flag outputs
`default_nettype none

module sst_sub_alu (
	// operands
	input wire logic [7:0] minuend,
	input wire logic [7:0] subtrahend,
	// result and flags
	output var sst_pkg::sst_sub_res_t res
);

	logic [8:0] full_sum;
	logic [4:0] low_sum;

	// ==========================================================
	// a + ~b + 1
	always_comb
	begin
		full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
		low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
		res.result = full_sum[7:0];
		res.flags.carry_flag = full_sum[8];
		res.flags.aux_carry_flag = low_sum[4];
		res.flags.zero_flag = (full_sum[7:0] == 8'h00);
		res.flags.overflow_flag = (minuend[7] != subtrahend[7]) && (full_sum[7] != minuend[7]);
	end

endmodule : sst_sub_alu

`default_nettype wire

// [rtl/sst_dmem.sv]
// data memory of flip-flops with one write port and two read ports
`default_nettype none
`include "sst_exec_cfg.svh"

module sst_dmem (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// write port
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	// read ports
	input wire logic [7:0] raddr_a,
	output logic [7:0] rdata_a,
	input wire logic [7:0] raddr_b,
	output logic [7:0] rdata_b
);

	logic [7:0] mem [0:`SST_DM_DEPTH-1];

	// ==========================================================
	// storage, addresses past the end write nothing
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < `SST_DM_DEPTH; i++)
				mem[i] <= 8'h00;
		end
		else if (we && (waddr < 8'(`SST_DM_DEPTH)))
			mem[waddr] <= wdata;
	end

	// ==========================================================
	// reads, addresses past the end read zero
	always_comb
	begin
		rdata_a = (raddr_a < 8'(`SST_DM_DEPTH)) ? mem[raddr_a] : 8'h00;
		rdata_b = (raddr_b < 8'(`SST_DM_DEPTH)) ? mem[raddr_b] : 8'h00;
	end

endmodule : sst_dmem

`default_nettype wire

// [rtl/sst_exec_top.sv]
// execution unit for set, skip, subtract, swap and table-read instructions
//
// Decided for this implementation: the APB slave port and the register addresses.
`default_nettype none
`include "sst_exec_cfg.svh"

// Operation
// - whole-byte set writes FFH, flags kept
// - bit set forces one bit, flags kept
// - increment to memory, skip on zero
// - increment into accumulator, skip on zero
// - decrement into accumulator, skip on zero
// - skip discards fetch, adds dummy cycle
// - skip when selected bit is one
// - subtract operand from accumulator, update flags
// - subtract result written to memory byte
// - swap nibbles of memory byte in place
// - swapped byte into accumulator, memory kept
// - skip when memory byte is zero
// - copy byte to accumulator, skip if zero
// - skip when selected bit is zero
// - table read: low byte memory, high latch
module sst_exec_top (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// program memory, data valid in the same cycle as prog_rd
	output logic [11:0] prog_addr,
	output logic prog_rd,
	input wire logic [14:0] prog_data
);
	default clocking sva_cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// state
	sst_pkg::sst_state_t state, next_state;
	sst_pkg::sst_cmd_t cmd, next_cmd;
	sst_pkg::sst_flags_t flags, next_flags;
	logic [7:0] acc, next_acc;
	logic [11:0] pc, next_pc;
	logic [7:0] table_pointer, next_table_pointer;
	logic [6:0] table_high_latch, next_table_high_latch;
	logic [7:0] dm_addr, next_dm_addr;
	logic last_skip, next_last_skip;
	logic [11:0] next_prog_addr;
	logic [31:0] next_prdata;
	logic next_prog_rd, next_pready, next_pslverr;
	logic [7:0] operand, bus_rdata, bit_mask, incr_val, decr_val, swap_val;
	logic [7:0] sub_b, ex_wdata;
	logic ex_we, ex_skip, bus_we, bus_dm_we, dm_we, busy;
	logic [7:0] dm_waddr, dm_wdata;
	sst_pkg::sst_sub_res_t sub_res;

	assign busy = (state != sst_pkg::st_idle);
	assign bus_we = psel && penable && pready && pwrite;
	assign bus_dm_we = bus_we && !busy && (paddr == `SST_REG_DM_DATA);
	assign bit_mask = 8'(8'h01 << cmd.bit_sel);
	assign incr_val = 8'(operand + 8'h01);
	assign decr_val = 8'(operand - 8'h01);
	assign swap_val = {operand[3:0], operand[7:4]};
	assign sub_b = (cmd.op == sst_pkg::op_sub_imm) ? cmd.imm : operand;
	assign dm_we = ex_we || bus_dm_we;
	assign dm_waddr = busy ? cmd.addr : dm_addr;
	assign dm_wdata = busy ? ex_wdata : pwdata[7:0];

	sst_dmem u_dmem (
		.clk(clk),
		.sys_rst(sys_rst),
		.we(dm_we),
		.waddr(dm_waddr),
		.wdata(dm_wdata),
		.raddr_a(cmd.addr),
		.rdata_a(operand),
		.raddr_b(dm_addr),
		.rdata_b(bus_rdata)
	);

	sst_sub_alu u_sub (
		.minuend(acc),
		.subtrahend(sub_b),
		.res(sub_res)
	);

	// ==========================================================
	// sequencer and execution
	always_comb
	begin
		next_state = state;
		next_cmd = cmd;
		next_flags = flags;
		next_acc = acc;
		next_pc = pc;
		next_table_pointer = table_pointer;
		next_table_high_latch = table_high_latch;
		next_dm_addr = dm_addr;
		next_last_skip = last_skip;
		next_prog_addr = prog_addr;
		next_prog_rd = 1'b0;
		ex_we = 1'b0;
		ex_wdata = operand;
		ex_skip = 1'b0;
		if (bus_we && (paddr == `SST_REG_DM_ADDR))
			next_dm_addr = pwdata[7:0];
		case (state)
			sst_pkg::st_idle:
			begin
				if (bus_we)
				begin
					if (paddr == `SST_REG_CMD)
					begin
						next_cmd.op = sst_pkg::sst_op_t'(pwdata[`SST_CMD_OP_MSB:`SST_CMD_OP_LSB]);
						next_cmd.addr = pwdata[`SST_CMD_ADDR_MSB:`SST_CMD_ADDR_LSB];
						next_cmd.bit_sel = pwdata[`SST_CMD_BIT_MSB:`SST_CMD_BIT_LSB];
						next_cmd.imm = pwdata[`SST_CMD_IMM_MSB:`SST_CMD_IMM_LSB];
						next_state = sst_pkg::st_exec;
					end
					else if (paddr == `SST_REG_ACC)
						next_acc = pwdata[7:0];
					else if (paddr == `SST_REG_FLAGS)
						next_flags = sst_pkg::sst_flags_t'(pwdata[3:0]);
					else if (paddr == `SST_REG_TABLE_PTR)
						next_table_pointer = pwdata[7:0];
					else if (paddr == `SST_REG_PC)
						next_pc = pwdata[11:0];
				end
			end
			sst_pkg::st_exec:
			begin
				case (cmd.op)
					sst_pkg::op_set_byte:
					begin
						ex_we = 1'b1;
						ex_wdata = `SST_SET_BYTE_VAL;
					end
					sst_pkg::op_set_bit:
					begin
						ex_we = 1'b1;
						ex_wdata = operand | bit_mask;
					end
					sst_pkg::op_incr_skip_zero:
					begin
						ex_we = 1'b1;
						ex_wdata = incr_val;
						ex_skip = (incr_val == 8'h00);
					end
					sst_pkg::op_incr_to_acc_skip_zero:
					begin
						next_acc = incr_val;
						ex_skip = (incr_val == 8'h00);
					end
					sst_pkg::op_decr_to_acc_skip_zero:
					begin
						next_acc = decr_val;
						ex_skip = (decr_val == 8'h00);
					end
					sst_pkg::op_skip_bit_set:
						ex_skip = |(operand & bit_mask);
					sst_pkg::op_sub_mem, sst_pkg::op_sub_imm:
					begin
						next_acc = sub_res.result;
						next_flags = sub_res.flags;
					end
					sst_pkg::op_subtract_to_memory:
					begin
						ex_we = 1'b1;
						ex_wdata = sub_res.result;
						next_flags = sub_res.flags;
					end
					sst_pkg::op_swap:
					begin
						ex_we = 1'b1;
						ex_wdata = swap_val;
					end
					sst_pkg::op_nibble_swap_to_acc:
						next_acc = swap_val;
					sst_pkg::op_skip_if_zero:
						ex_skip = (operand == 8'h00);
					sst_pkg::op_move_skip_if_zero:
					begin
						next_acc = operand;
						ex_skip = (operand == 8'h00);
					end
					sst_pkg::op_skip_bit_clear:
						ex_skip = ((operand & bit_mask) == 8'h00);
					sst_pkg::op_table_read_current_page:
					begin
						next_prog_addr = {pc[`SST_PAGE_MSB:`SST_PAGE_LSB], table_pointer};
						next_prog_rd = 1'b1;
					end
					default:
						ex_we = 1'b0;
				endcase
				next_pc = 12'(pc + 12'h001);
				next_last_skip = ex_skip;
				if (cmd.op == sst_pkg::op_table_read_current_page)
					next_state = sst_pkg::st_tbl_wait;
				else if (ex_skip)
					next_state = sst_pkg::st_dummy;
				else
					next_state = sst_pkg::st_idle;
			end
			sst_pkg::st_dummy:
			begin
				next_pc = 12'(pc + 12'h001);
				next_state = sst_pkg::st_idle;
			end
			sst_pkg::st_tbl_wait:
			begin
				ex_we = 1'b1;
				ex_wdata = prog_data[7:0];
				next_table_high_latch = prog_data[14:8];
				next_state = sst_pkg::st_idle;
			end
			default:
				next_state = sst_pkg::st_idle;
		endcase
	end

	// ==========================================================
	// apb answer, ready in the second access cycle
	always_comb
	begin
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (next_pready)
		begin
			if (paddr == `SST_REG_CMD)
				next_prdata = {8'h00, cmd.imm, 1'b0, cmd.bit_sel, cmd.addr, cmd.op};
			else if (paddr == `SST_REG_STATUS)
				next_prdata = {30'h0, last_skip, busy};
			else if (paddr == `SST_REG_ACC)
				next_prdata = {24'h00_0000, acc};
			else if (paddr == `SST_REG_FLAGS)
				next_prdata = {28'h000_0000, flags};
			else if (paddr == `SST_REG_TABLE_PTR)
				next_prdata = {24'h00_0000, table_pointer};
			else if (paddr == `SST_REG_TABLE_HIGH)
				next_prdata = {25'h0, table_high_latch};
			else if (paddr == `SST_REG_PC)
				next_prdata = {20'h0_0000, pc};
			else if (paddr == `SST_REG_DM_ADDR)
				next_prdata = {24'h00_0000, dm_addr};
			else if (paddr == `SST_REG_DM_DATA)
				next_prdata = {24'h00_0000, bus_rdata};
			else
				next_pslverr = 1'b1;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= sst_pkg::st_idle;
			cmd <= '0;
			flags <= sst_pkg::sst_flags_t'(`SST_FLAGS_RST);
			acc <= `SST_ACC_RST;
			pc <= `SST_PC_RST;
			table_pointer <= `SST_TABLE_PTR_RST;
			table_high_latch <= `SST_TABLE_HIGH_RST;
			dm_addr <= 8'h00;
			last_skip <= 1'b0;
			prog_addr <= 12'h000;
			prog_rd <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cmd <= next_cmd;
			flags <= next_flags;
			acc <= next_acc;
			pc <= next_pc;
			table_pointer <= next_table_pointer;
			table_high_latch <= next_table_high_latch;
			dm_addr <= next_dm_addr;
			last_skip <= next_last_skip;
			prog_addr <= next_prog_addr;
			prog_rd <= next_prog_rd;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ==========================================================
	// assertions
	sequence s_exec(sst_pkg::sst_op_t o);
		state == sst_pkg::st_exec && cmd.op == o;
	endsequence
	sequence s_skip_exec;
		state == sst_pkg::st_exec && ex_skip;
	endsequence
	property p_set_byte;
		s_exec(sst_pkg::op_set_byte) |-> dm_we && dm_wdata == 8'hFF ##1 flags == $past(flags);
	endproperty
	a_set_byte: assert property (p_set_byte) else $error("set byte wrong");
	property p_set_bit;
		s_exec(sst_pkg::op_set_bit) |-> dm_we && dm_wdata[cmd.bit_sel] && ((dm_wdata ^ operand) & ~bit_mask) == 8'h00;
	endproperty
	a_set_bit: assert property (p_set_bit) else $error("bit set wrong");
	property p_incr_skip;
		s_exec(sst_pkg::op_incr_skip_zero) and operand == 8'hFF |-> dm_we && dm_wdata == 8'h00
			##1 state == sst_pkg::st_dummy;
	endproperty
	a_incr_skip: assert property (p_incr_skip) else $error("increment skip wrong");
	property p_incr_acc;
		s_exec(sst_pkg::op_incr_to_acc_skip_zero) |-> !dm_we ##1 acc == 8'($past(operand) + 8'h01);
	endproperty
	a_incr_acc: assert property (p_incr_acc) else $error("increment to acc wrong");
	property p_decr_acc;
		s_exec(sst_pkg::op_decr_to_acc_skip_zero) and operand == 8'h01 |=> acc == 8'h00
			&& state == sst_pkg::st_dummy && flags == $past(flags);
	endproperty
	a_decr_acc: assert property (p_decr_acc) else $error("decrement to acc wrong");
	property p_skip_two;
		s_skip_exec |=> state == sst_pkg::st_dummy ##1 state == sst_pkg::st_idle && pc == 12'($past(pc, 2) + 12'h002);
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");
	property p_bit_test;
		s_exec(sst_pkg::op_skip_bit_set) or s_exec(sst_pkg::op_skip_bit_clear)
			|-> !dm_we && (ex_skip == (operand[cmd.bit_sel] == (cmd.op == sst_pkg::op_skip_bit_set)));
	endproperty
	a_bit_test: assert property (p_bit_test) else $error("bit test skip wrong");
	property p_sub_acc;
		s_exec(sst_pkg::op_sub_mem) |=> acc == 8'($past(acc) - $past(operand))
			&& flags.carry_flag == ($past(acc) >= $past(operand)) && flags.zero_flag == (acc == 8'h00);
	endproperty
	a_sub_acc: assert property (p_sub_acc) else $error("subtract wrong");
	property p_sub_mem;
		s_exec(sst_pkg::op_subtract_to_memory) |-> dm_we && dm_wdata == 8'(acc - operand) ##1 acc == $past(acc);
	endproperty
	a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");
	property p_swap;
		s_exec(sst_pkg::op_swap) |-> dm_we && dm_wdata[3:0] == operand[7:4] && dm_wdata[7:4] == operand[3:0];
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");
	property p_zero_test;
		s_exec(sst_pkg::op_skip_if_zero) or s_exec(sst_pkg::op_move_skip_if_zero)
			|-> !dm_we && ex_skip == (operand == 8'h00);
	endproperty
	a_zero_test: assert property (p_zero_test) else $error("zero test wrong");
	property p_table;
		s_exec(sst_pkg::op_table_read_current_page) |=> prog_rd
			&& prog_addr == {$past(pc[11:8]), table_pointer} ##1 table_high_latch == $past(prog_data[14:8]);
	endproperty
	a_table: assert property (p_table) else $error("table read wrong");

endmodule : sst_exec_top

`default_nettype wire

// [rtl/sst_exec_top_note.sv]
// no logic here; the execution unit and its helpers sit in the other rtl files
`default_nettype none
`default_nettype wire

// [bench/sst_prog_model.sv]
// program memory model answering table reads
`default_nettype none

module sst_prog_model (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// program port
	input wire logic [11:0] prog_addr,
	input wire logic prog_rd,
	output logic [14:0] prog_data
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [14:0] junk;

	// ==========================================================
	// word valid only in the read pulse, a changing pattern otherwise
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			junk <= 15'h2AAA;
		else
			junk <= ~junk;
	end

	assign prog_data = prog_rd ? {prog_addr[11:5], prog_addr[7:0] ^ 8'hC3} : junk;
endmodule : sst_prog_model

`default_nettype wire

// [bench/testbench.sv]
// self-checking testbench of the execution block
`default_nettype none
`include "sst_exec_cfg.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, prog_rd, last_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [11:0] prog_addr;
	logic [14:0] prog_data;
	int failures, n_checks;
	localparam logic [11:0] PC_BASE = 12'h2F0;

	// ==========================================================
	// design and program memory
	sst_exec_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data));
	sst_prog_model u_prog (.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_rd(prog_rd),
		.prog_data(prog_data));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================================
	// shared tasks
	task automatic print_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			failures++;
			print_verdict();
		end
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic prep(input logic [7:0] acc, input logic [7:0] a, input logic [7:0] m);
		apb(1'b1, `SST_REG_ACC, {24'h0, acc});
		apb(1'b1, `SST_REG_FLAGS, 32'h9);
		apb(1'b1, `SST_REG_DM_ADDR, {24'h0, a});
		apb(1'b1, `SST_REG_DM_DATA, {24'h0, m});
	endtask : prep

	task automatic after(input logic [7:0] acc, input logic [7:0] m, input logic [3:0] fl);
		apb(1'b0, `SST_REG_ACC, 32'h0);
		check(q, {24'h0, acc});
		apb(1'b0, `SST_REG_DM_DATA, 32'h0);
		check(q, {24'h0, m});
		apb(1'b0, `SST_REG_FLAGS, 32'h0);
		check(q, {28'h0, fl});
	endtask : after

	task automatic run(input logic [3:0] op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] imm,
		input logic sk);
		int i;
		apb(1'b1, `SST_REG_PC, {20'h0, PC_BASE});
		apb(1'b1, `SST_REG_CMD, {8'h00, imm, 1'b0, b, a, op});
		for (i = 0; i < 10; i++)
		begin
			apb(1'b0, `SST_REG_STATUS, 32'h0);
			if (q[0] === 1'b0)
				break;
		end
		if (i == 10)
		begin
			failures++;
			print_verdict();
		end
		check(q, {30'h0, sk, 1'b0});
		apb(1'b0, `SST_REG_PC, 32'h0);
		check(q, {20'h0, PC_BASE + 12'h001 + {11'h0, sk}});
	endtask : run

	function automatic logic [11:0] sub_exp(input logic [7:0] a, input logic [7:0] b);
		int s;
		logic [7:0] r;
		s = int'($signed(a)) - int'($signed(b));
		r = 8'(a - b);
		return {(s > 127) || (s < -128), (r == 8'h00), (a[3:0] >= b[3:0]), (a >= b), r};
	endfunction : sub_exp

	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] regs [7] = '{`SST_REG_STATUS, `SST_REG_ACC, `SST_REG_FLAGS, `SST_REG_TABLE_PTR,
			`SST_REG_TABLE_HIGH, `SST_REG_PC, `SST_REG_DM_ADDR};
		foreach (regs[i])
		begin
			apb(1'b0, regs[i], 32'h0);
			check(q, 32'h0);
			check({31'h0, last_err}, 32'h0);
		end
		apb(1'b1, 8'h24, 32'h5);
		check({31'h0, last_err}, 32'h1);
		apb(1'b0, 8'h24, 32'h0);
		check({31'h0, last_err}, 32'h1);
		check(q, 32'h0);
		$display("test reset and unmapped done");
	endtask : t_reset

	task automatic t_set_incr();
		prep(8'h11, 8'h05, 8'h12); run(4'h0, 8'h05, 3'h0, 8'h00, 1'b0); after(8'h11, 8'hFF, 4'h9);
		prep(8'h11, 8'h06, 8'h10); run(4'h1, 8'h06, 3'h7, 8'h00, 1'b0); after(8'h11, 8'h90, 4'h9);
		prep(8'h11, 8'h07, 8'hFF); run(4'h2, 8'h07, 3'h0, 8'h00, 1'b1); after(8'h11, 8'h00, 4'h9);
		prep(8'h11, 8'h07, 8'h07); run(4'h2, 8'h07, 3'h0, 8'h00, 1'b0); after(8'h11, 8'h08, 4'h9);
		prep(8'h11, 8'h08, 8'hFF); run(4'h3, 8'h08, 3'h0, 8'h00, 1'b1); after(8'h00, 8'hFF, 4'h9);
		prep(8'h11, 8'h08, 8'h3F); run(4'h3, 8'h08, 3'h0, 8'h00, 1'b0); after(8'h40, 8'h3F, 4'h9);
		prep(8'h11, 8'h09, 8'h01); run(4'h4, 8'h09, 3'h0, 8'h00, 1'b1); after(8'h00, 8'h01, 4'h9);
		prep(8'h11, 8'h09, 8'h00); run(4'h4, 8'h09, 3'h0, 8'h00, 1'b0); after(8'hFF, 8'h00, 4'h9);
		$display("test set and increment done");
	endtask : t_set_incr

	task automatic t_tests();
		prep(8'h11, 8'h0A, 8'h08);
		run(4'h5, 8'h0A, 3'h3, 8'h00, 1'b1);
		run(4'h5, 8'h0A, 3'h2, 8'h00, 1'b0);
		run(4'hD, 8'h0A, 3'h2, 8'h00, 1'b1);
		run(4'hD, 8'h0A, 3'h3, 8'h00, 1'b0);
		after(8'h11, 8'h08, 4'h9);
		prep(8'h11, 8'h0B, 8'h00);
		run(4'hB, 8'h0B, 3'h0, 8'h00, 1'b1);
		run(4'hC, 8'h0B, 3'h0, 8'h00, 1'b1); after(8'h00, 8'h00, 4'h9);
		prep(8'h11, 8'h0B, 8'h44);
		run(4'hB, 8'h0B, 3'h0, 8'h00, 1'b0);
		run(4'hC, 8'h0B, 3'h0, 8'h00, 1'b0); after(8'h44, 8'h44, 4'h9);
		run(4'hF, 8'h0B, 3'h0, 8'h00, 1'b0); after(8'h44, 8'h44, 4'h9);
		$display("test skip conditions done");
	endtask : t_tests

	task automatic t_swap_sub();
		logic [15:0] pairs [5] = '{16'h5070, 16'h7070, 16'h8001, 16'h050F, 16'h7FFF};
		logic [11:0] e;
		prep(8'h11, 8'h0C, 8'h3C); run(4'h9, 8'h0C, 3'h0, 8'h00, 1'b0); after(8'h11, 8'hC3, 4'h9);
		prep(8'h11, 8'h0C, 8'h5A); run(4'hA, 8'h0C, 3'h0, 8'h00, 1'b0); after(8'hA5, 8'h5A, 4'h9);
		foreach (pairs[i])
		begin
			e = sub_exp(pairs[i][15:8], pairs[i][7:0]);
			prep(pairs[i][15:8], 8'h0D, pairs[i][7:0]);
			run(4'h6, 8'h0D, 3'h0, 8'h00, 1'b0); after(e[7:0], pairs[i][7:0], e[11:8]);
			prep(pairs[i][15:8], 8'h0D, 8'h00);
			run(4'h7, 8'h0D, 3'h0, pairs[i][7:0], 1'b0); after(e[7:0], 8'h00, e[11:8]);
			prep(pairs[i][15:8], 8'h0D, pairs[i][7:0]);
			run(4'h8, 8'h0D, 3'h0, 8'h00, 1'b0); after(pairs[i][15:8], e[7:0], e[11:8]);
		end
		$display("test swap and subtract done");
	endtask : t_swap_sub

	task automatic t_table();
		apb(1'b1, `SST_REG_TABLE_PTR, 32'h47);
		prep(8'h11, 8'h0E, 8'h00);
		run(4'hE, 8'h0E, 3'h0, 8'h00, 1'b0);
		check({20'h0, prog_addr}, 32'h247);
		apb(1'b0, `SST_REG_CMD, 32'h0);
		check(q, 32'h0000_00EE);
		after(8'h11, 8'h84, 4'h9);
		apb(1'b0, `SST_REG_TABLE_HIGH, 32'h0);
		check(q, 32'h12);
		$display("test table read done");
	endtask : t_table

	// ==========================================================
	// main sequence
	initial
	begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		failures = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_set_incr();
		t_tests();
		t_swap_sub();
		t_table();
		print_verdict();
	end
endmodule : testbench

`default_nettype wire
